// >>> rtl/mdc_defs.vh
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH
// clock period in ns (50 MHz)
`define MDC_CLK_NS        20
// power-up pause and warm-up cycles
`define MDC_PWRUP_NS      100000
`define MDC_PWRUP_CYC     ((`MDC_PWRUP_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_WARMUP_CNT    8
// distributed refresh interval, longest, in ps
`define MDC_REFI_PS       15625000
`define MDC_REFI_CYC      ((`MDC_REFI_PS / 1000) / `MDC_CLK_NS)
`define MDC_ROWS          256
// margin for an access in flight when a refresh falls due
`define MDC_REF_SLACK_CYC 64
// strobe timing, least times in ns, rounded up to cycles
`define MDC_RAS_PRE_NS    90
`define MDC_RAS_PRE_CYC   ((`MDC_RAS_PRE_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_ROW_HOLD_NS   20
`define MDC_ROW_HOLD_CYC  ((`MDC_ROW_HOLD_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_CAS_NS        150
`define MDC_CAS_CYC       ((`MDC_CAS_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_PAGE_PRE_NS   35
`define MDC_PAGE_PRE_CYC  ((`MDC_PAGE_PRE_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_WP_NS         45
`define MDC_WP_CYC        ((`MDC_WP_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_RMW_EXTRA_NS  40
`define MDC_CWD_NS        (60 + `MDC_RMW_EXTRA_NS)
`define MDC_CWD_CYC       ((`MDC_CWD_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_CBR_SET_NS    10
`define MDC_CBR_SET_CYC   ((`MDC_CBR_SET_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
// commands
`define MDC_CMD_READ      2'h0
`define MDC_CMD_WRITE     2'h1
`define MDC_CMD_RMW       2'h2
`endif

// >>> rtl/mdc_timer.v
`timescale 1ns/1ns
// down counter; done is high when it has run out
module mdc_timer (
   input  wire        clk,
   input  wire        rst,
   input  wire        load,
   input  wire [17:0] value,
   output wire        done
);
   reg [17:0] cnt_ff;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 18'h0;
      end else if (load) begin
         cnt_ff <= value;
      end else if (cnt_ff != 18'h0) begin
         cnt_ff <= cnt_ff - 18'h1;
      end
   end
   assign done = (cnt_ff == 18'h0);
endmodule // mdc_timer

// >>> rtl/mdc_ctrl.v
`timescale 1ns/1ns
// What this block does
// - wait 100us then eight row cycles
// - pulse column high for page precharge
// - tied enable: read then separate write
// - neither write form: output undefined
// - data timed to column or write fall
// - add 40 ns to the column-to-write delay
// - row-only refresh on low address
// - refresh one row every 717 cycles (14.34us), inside the 15.625us interval
// - distributed refresh covers all rows within 4ms
// - row half then column half
// - page accesses within open row
`include "mdc_defs.vh"
module mdc_ctrl (
   input  wire        CLK_SYS,
   input  wire        RST,
   input  wire        REQ_VALID,
   input  wire [1:0]  REQ_CMD,
   input  wire [15:0] REQ_ADDR,
   input  wire [3:0]  REQ_WDATA,
   input  wire        CBR_MODE,
   input  wire [3:0]  DQ_IN,
   output reg         REQ_READY,
   output reg         RSP_VALID,
   output reg  [3:0]  RSP_RDATA,
   output reg         INIT_DONE,
   output reg         ROW_STROBE_N,
   output reg         COL_STROBE_N,
   output reg         WRITE_STROBE_N,
   output reg         OUT_ENABLE_N,
   output reg  [7:0]  ADDR,
   output reg  [3:0]  DIN
);
   localparam S_PWRUP = 4'h0;
   localparam S_IDLE  = 4'h1;
   localparam S_RPRE  = 4'h2;
   localparam S_ROW   = 4'h3;
   localparam S_COL   = 4'h4;
   localparam S_CAS   = 4'h5;
   localparam S_WLATE = 4'h6;
   localparam S_CPRE  = 4'h7;
   localparam S_REF   = 4'h8;
   localparam S_CBR   = 4'h9;
   localparam S_WARM  = 4'ha;

   reg  [3:0]  st_ff;
   reg  [3:0]  nxt_st;
   reg  [3:0]  warm_ff;
   reg         row_open_ff;
   reg  [7:0]  open_row_ff;
   reg  [7:0]  ref_row_ff;
   reg  [1:0]  cmd_ff;
   reg  [7:0]  col_ff;
   reg  [7:0]  row_ff;
   reg  [3:0]  wd_ff;
   reg         ref_due_ff;
   reg         tm_load;
   reg  [17:0] tm_val;
   wire        tm_done;
   wire        rf_done;
   wire        rf_load;
   wire        ref_clr;
   wire        nxt_ref_due;
   reg         pend_ff;
   reg         pwr_arm_ff;
   // timing counts cut to the timer width
   localparam [31:0] C_PWRUP = `MDC_PWRUP_CYC;
   localparam [31:0] C_RPRE  = `MDC_RAS_PRE_CYC;
   localparam [31:0] C_CAS   = `MDC_CAS_CYC;
   localparam [31:0] C_CWD   = `MDC_CWD_CYC;
   localparam [31:0] C_WP    = `MDC_WP_CYC;
   localparam [31:0] C_CPRE  = `MDC_PAGE_PRE_CYC;
   localparam [31:0] C_CBR   = `MDC_CBR_SET_CYC;
   localparam [31:0] C_REFLD = `MDC_REFI_CYC - `MDC_REF_SLACK_CYC - 1;

   // one timer paces strobes, a second paces refresh
   mdc_timer u_tm (
      .clk   (CLK_SYS),
      .rst   (RST),
      .load  (tm_load),
      .value (tm_val),
      .done  (tm_done)
   );
   mdc_timer u_rf (
      .clk   (CLK_SYS),
      .rst   (RST),
      .load  (rf_load),
      .value (C_REFLD[17:0]),
      .done  (rf_done)
   );

   always @* begin
      nxt_st  = st_ff;
      tm_load = 1'b0;
      tm_val  = 18'h0;
      case (st_ff)
         S_PWRUP: begin
            // the pause is loaded once, on the first edge after reset
            if (!pwr_arm_ff) begin
               tm_load = 1'b1;
               tm_val  = C_PWRUP[17:0];
            end else if (tm_done) begin
               nxt_st  = S_RPRE;
               tm_load = 1'b1;
               tm_val  = C_RPRE[17:0];
            end
         end
         S_IDLE: begin
            if (ref_due_ff || (REQ_VALID && REQ_READY)) begin
               // close a row that is open and not the target
               if (row_open_ff && (ref_due_ff ||
                   REQ_ADDR[15:8] != open_row_ff)) begin
                  nxt_st  = S_RPRE;
                  tm_load = 1'b1;
                  tm_val  = C_RPRE[17:0];
               end else if (row_open_ff) begin
                  nxt_st = S_COL;
               end else begin
                  nxt_st = ref_due_ff ? (CBR_MODE ? S_CBR : S_REF) : S_ROW;
                  tm_load = 1'b1;
                  tm_val  = (ref_due_ff && CBR_MODE) ? C_CBR[17:0]
                                                     : C_CAS[17:0];
               end
            end
         end
         S_RPRE: begin
            // a request that missed the open row reopens from here
            if (tm_done) begin
               nxt_st  = !INIT_DONE ? S_WARM : (pend_ff ? S_ROW : S_IDLE);
               tm_load = 1'b1;
               tm_val  = C_CAS[17:0];
            end
         end
         S_WARM: begin
            if (tm_done) begin
               nxt_st  = S_RPRE;
               tm_load = 1'b1;
               tm_val  = C_RPRE[17:0];
            end
         end
         S_ROW: begin
            if (tm_done) begin
               nxt_st = S_COL;
            end
         end
         S_COL: begin
            nxt_st  = S_CAS;
            tm_load = 1'b1;
            tm_val  = (cmd_ff == `MDC_CMD_RMW) ? C_CWD[17:0] : C_CAS[17:0];
         end
         S_CAS: begin
            if (tm_done) begin
               nxt_st  = (cmd_ff == `MDC_CMD_RMW) ? S_WLATE : S_CPRE;
               tm_load = 1'b1;
               tm_val  = (cmd_ff == `MDC_CMD_RMW) ? C_WP[17:0]
                                                   : C_CPRE[17:0];
            end
         end
         S_WLATE: begin
            if (tm_done) begin
               nxt_st  = S_CPRE;
               tm_load = 1'b1;
               tm_val  = C_CPRE[17:0];
            end
         end
         S_CPRE: begin
            if (tm_done) begin
               nxt_st = S_IDLE;
            end
         end
         S_REF: begin
            if (tm_done) begin
               nxt_st  = S_RPRE;
               tm_load = 1'b1;
               tm_val  = C_RPRE[17:0];
            end
         end
         S_CBR: begin
            if (tm_done) begin
               nxt_st  = S_REF;
               tm_load = 1'b1;
               tm_val  = C_CAS[17:0];
            end
         end
         default: begin
            nxt_st = S_IDLE;
         end
      endcase
   end

   // reload as the demand is raised, so waiting behind an access does
   // not stretch the pace; the slack covers that wait
   assign rf_load     = INIT_DONE && rf_done;
   assign ref_clr     = (st_ff == S_REF) && tm_done;
   assign nxt_ref_due = rf_load || (ref_due_ff && !ref_clr);

   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         st_ff          <= S_PWRUP;
         warm_ff        <= 4'h0;
         row_open_ff    <= 1'b0;
         open_row_ff    <= 8'h0;
         ref_row_ff     <= 8'h0;
         cmd_ff         <= 2'h0;
         col_ff         <= 8'h0;
         row_ff         <= 8'h0;
         wd_ff          <= 4'h0;
         pend_ff        <= 1'b0;
         ref_due_ff     <= 1'b0;
         REQ_READY      <= 1'b0;
         RSP_VALID      <= 1'b0;
         RSP_RDATA      <= 4'h0;
         INIT_DONE      <= 1'b0;
         ROW_STROBE_N   <= 1'b1;
         COL_STROBE_N   <= 1'b1;
         WRITE_STROBE_N <= 1'b1;
         OUT_ENABLE_N   <= 1'b1;
         ADDR           <= 8'h0;
         DIN            <= 4'h0;
      end else begin
         st_ff     <= nxt_st;
         RSP_VALID <= 1'b0;
         // never offer a slot that a refresh is about to take
         REQ_READY  <= (nxt_st == S_IDLE) && INIT_DONE && !nxt_ref_due;
         // refresh demand; a new demand wins over the clear
         ref_due_ff <= nxt_ref_due;
         case (st_ff)
            S_PWRUP: begin
               if (tm_done) begin
                  ROW_STROBE_N <= 1'b1;
               end
            end
            S_WARM: begin
               ROW_STROBE_N <= 1'b0;
               if (tm_done) begin
                  ROW_STROBE_N <= 1'b1;
                  warm_ff      <= warm_ff + 4'h1;
                  if (warm_ff == `MDC_WARMUP_CNT - 1) begin
                     INIT_DONE <= 1'b1;
                  end
               end
            end
            S_IDLE: begin
               if (REQ_VALID && REQ_READY) begin
                  cmd_ff <= REQ_CMD;
                  row_ff <= REQ_ADDR[15:8];
                  col_ff <= REQ_ADDR[7:0];
                  wd_ff  <= REQ_WDATA;
               end
               if (nxt_st == S_RPRE) begin
                  ROW_STROBE_N <= 1'b1;
                  row_open_ff  <= 1'b0;
                  pend_ff      <= REQ_VALID && REQ_READY;
               end else if (nxt_st == S_ROW) begin
                  ADDR         <= REQ_ADDR[15:8];
                  ROW_STROBE_N <= 1'b0;
                  row_open_ff  <= 1'b1;
                  open_row_ff  <= REQ_ADDR[15:8];
               end else if (nxt_st == S_REF) begin
                  ADDR         <= ref_row_ff;
                  ROW_STROBE_N <= 1'b0;
                  ref_row_ff   <= ref_row_ff + 8'h1;
               end else if (nxt_st == S_CBR) begin
                  COL_STROBE_N <= 1'b0;
               end
            end
            S_RPRE: begin
               if (tm_done && pend_ff) begin
                  ADDR         <= row_ff;
                  ROW_STROBE_N <= 1'b0;
                  row_open_ff  <= 1'b1;
                  open_row_ff  <= row_ff;
                  pend_ff      <= 1'b0;
               end
            end
            S_ROW: begin
               if (tm_done) begin
                  ADDR <= col_ff;
               end
            end
            S_COL: begin
               ADDR           <= col_ff;
               DIN            <= wd_ff;
               COL_STROBE_N   <= 1'b0;
               // write strobe low on the same edge as column fall gives early write
               if (cmd_ff == `MDC_CMD_WRITE) begin
                  WRITE_STROBE_N <= 1'b0;
                  OUT_ENABLE_N   <= 1'b1;
               end else begin
                  OUT_ENABLE_N <= 1'b0;
               end
            end
            S_CAS: begin
               if (tm_done) begin
                  if (cmd_ff != `MDC_CMD_WRITE) begin
                     // sample read data, valid after access time
                     RSP_RDATA <= DQ_IN;
                  end
                  if (cmd_ff == `MDC_CMD_RMW) begin
                     OUT_ENABLE_N   <= 1'b1;
                     WRITE_STROBE_N <= 1'b0;
                  end else begin
                     COL_STROBE_N   <= 1'b1;
                     WRITE_STROBE_N <= 1'b1;
                     OUT_ENABLE_N   <= 1'b1;
                     RSP_VALID      <= 1'b1;
                  end
               end
            end
            S_WLATE: begin
               if (tm_done) begin
                  WRITE_STROBE_N <= 1'b1;
                  COL_STROBE_N   <= 1'b1;
                  RSP_VALID      <= 1'b1;
               end
            end
            S_CBR: begin
               if (tm_done) begin
                  ROW_STROBE_N <= 1'b0;
               end
            end
            S_REF: begin
               if (tm_done) begin
                  ROW_STROBE_N <= 1'b1;
                  COL_STROBE_N <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end
   // one-shot that loads the power-up pause after every reset
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         pwr_arm_ff <= 1'b0;
      end else begin
         pwr_arm_ff <= 1'b1;
      end
   end
endmodule // mdc_ctrl

// >>> verif/mdc_dram_model.sv
`timescale 1ns/1ns
// 64k x 4 memory; answers ACC_NS after the column strobe
module mdc_dram_model #(
   parameter ACC_NS = 40
) (
   input  wire       row_strobe_n,
   input  wire       col_strobe_n,
   input  wire       write_strobe_n,
   input  wire       out_enable_n,
   input  wire [7:0] addr,
   input  wire [3:0] din,
   output wire [3:0] dq
);
   reg [3:0] mem [0:65535];
   reg [7:0] row, col, rfsh_row;
   reg [3:0] dout, stale;
   reg       cbr, early;
   integer   k;
   initial begin
      for (k = 0; k < 65536; k = k + 1) mem[k] = 4'h0;
      row = 8'h00;
      rfsh_row = 8'h00;
      stale = 4'h5;
      cbr = 1'b0;
      early = 1'b1;
   end
   // column low first: own counter, address ignored, output untouched
   always @(negedge row_strobe_n) begin
      cbr = !col_strobe_n;
      if (cbr) rfsh_row = rfsh_row + 8'h01;
      else row = addr;
   end
   always @(negedge col_strobe_n) if (!row_strobe_n && !cbr) begin
      col = addr;
      early = !write_strobe_n;
      if (early) mem[{row, col}] = din;
      else dout <= #(ACC_NS) mem[{row, addr}];
   end
   // late write keeps the read data; its state is not to be relied on
   always @(negedge write_strobe_n)
      if (!col_strobe_n && !early && !cbr) mem[{row, col}] = din;
   // no pull on the data lines: released bus shows a changed value
   always @(posedge col_strobe_n or posedge out_enable_n) stale = ~dout;
   assign dq = (!col_strobe_n && !out_enable_n && !early) ? dout : stale;
endmodule // mdc_dram_model

// >>> verif/mdc_ctrl_monitor.sv
`timescale 1ns/1ns
module mdc_ctrl_monitor (
   input wire       CLK_SYS,
   input wire       RST,
   input wire       REQ_READY,
   input wire       INIT_DONE,
   input wire       ROW_STROBE_N,
   input wire       COL_STROBE_N,
   input wire       WRITE_STROBE_N,
   input wire       OUT_ENABLE_N,
   input wire [7:0] ADDR,
   input wire [3:0] DIN
);
   localparam int REF_GAP = 781;
   reg [3:0]  nfall_ff;
   reg [10:0] gap_ff;
   reg        row_q_ff;
   wire       row_fall = row_q_ff & ~ROW_STROBE_N;
   // gap saturates so a stuck row strobe keeps failing
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         nfall_ff <= 4'h0;
         gap_ff <= 11'h000;
         row_q_ff <= 1'b1;
      end else begin
         row_q_ff <= ROW_STROBE_N;
         if (row_fall && nfall_ff != 4'hf) nfall_ff <= nfall_ff + 4'h1;
         if (row_fall) gap_ff <= 11'h000;
         else if (gap_ff != 11'h7ff) gap_ff <= gap_ff + 11'h001;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_early;
      $fell(COL_STROBE_N) && !WRITE_STROBE_N;
   endsequence
   sequence s_late;
      $fell(WRITE_STROBE_N) && !COL_STROBE_N && !$past(COL_STROBE_N);
   endsequence
   property p_warm; $rose(INIT_DONE) |-> nfall_ff >= 4'h8; endproperty
   a_warm: assert property (p_warm) else $error("early init");
   property p_idle; !INIT_DONE |-> !REQ_READY; endproperty
   a_idle: assert property (p_idle) else $error("taken in init");
   property p_cpre; $rose(COL_STROBE_N) |-> COL_STROBE_N [*2]; endproperty
   a_cpre: assert property (p_cpre) else $error("short col high");
   property p_ewr; s_early |-> OUT_ENABLE_N [*3]; endproperty
   a_ewr: assert property (p_ewr) else $error("oe in write");
   property p_hold;
      !WRITE_STROBE_N && !COL_STROBE_N && !$past(WRITE_STROBE_N)
         && !$past(COL_STROBE_N) |-> $stable(DIN);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_lwd;
      s_late |-> !$past(COL_STROBE_N, 5) && !$past(ROW_STROBE_N, 9);
   endproperty
   a_lwd: assert property (p_lwd) else $error("late write early");
   property p_radr; $fell(ROW_STROBE_N) |=> $stable(ADDR); endproperty
   a_radr: assert property (p_radr) else $error("row addr moved");
   property p_rpre; $rose(ROW_STROBE_N) |-> ROW_STROBE_N [*5]; endproperty
   a_rpre: assert property (p_rpre) else $error("short row high");
   property p_gap; INIT_DONE |-> gap_ff < REF_GAP; endproperty
   a_gap: assert property (p_gap) else $error("refresh late");
endmodule // mdc_ctrl_monitor
bind mdc_ctrl mdc_ctrl_monitor i_mdc_ctrl_monitor (.CLK_SYS(CLK_SYS),
   .RST(RST), .REQ_READY(REQ_READY), .INIT_DONE(INIT_DONE),
   .ROW_STROBE_N(ROW_STROBE_N), .COL_STROBE_N(COL_STROBE_N),
   .WRITE_STROBE_N(WRITE_STROBE_N), .OUT_ENABLE_N(OUT_ENABLE_N),
   .ADDR(ADDR), .DIN(DIN));

// >>> verif/test_multiplexed_dram_cycle_rules.sv
`timescale 1ns/1ns
`include "mdc_defs.vh"
module test_multiplexed_dram_cycle_rules;
   reg        clk, rst, vld, cbr;
   reg [1:0]  cmd;
   reg [15:0] adr;
   reg [3:0]  wd;
   wire       rdy, rv, idone, row_n, col_n, we_n, oe_n;
   wire [3:0] rd, din, dq;
   wire [7:0] ma;
   reg [3:0]  ref_mem [0:65535];
   reg [4:0]  note_q [$];
   reg [4:0]  nt;
   integer    mismatches, cmp_count, cycles, seed, i, r;
   mdc_ctrl i_mdc_ctrl (.CLK_SYS(clk), .RST(rst), .REQ_VALID(vld),
      .REQ_CMD(cmd), .REQ_ADDR(adr), .REQ_WDATA(wd), .CBR_MODE(cbr),
      .DQ_IN(dq), .REQ_READY(rdy), .RSP_VALID(rv), .RSP_RDATA(rd),
      .INIT_DONE(idone), .ROW_STROBE_N(row_n), .COL_STROBE_N(col_n),
      .WRITE_STROBE_N(we_n), .OUT_ENABLE_N(oe_n), .ADDR(ma), .DIN(din));
   // slowest grade: data arrives at the column access limit
   mdc_dram_model #(.ACC_NS(75)) i_mdc_dram_model (.row_strobe_n(row_n),
      .col_strobe_n(col_n), .write_strobe_n(we_n), .out_enable_n(oe_n),
      .addr(ma), .din(din), .dq(dq));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task check(input [3:0] seen, input [3:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task finish_test;
      begin
         if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   // one request at a time; waits for its answer before returning
   task do_req(input [1:0] c, input [15:0] a, input [3:0] d);
      integer n;
      reg     taken;
      begin
         n = 0;
         taken = 1'b0;
         vld <= 1'b1;
         cmd <= c;
         adr <= a;
         wd <= d;
         // ready is read mid-cycle, as the next rising edge will see it
         while (!taken && n < 3000) begin
            @(negedge clk);
            taken = (rdy === 1'b1);
            @(posedge clk);
            n = n + 1;
         end
         vld <= 1'b0;
         note_q.push_back({c != `MDC_CMD_WRITE, ref_mem[a]});
         if (c != `MDC_CMD_READ) ref_mem[a] = d;
         while (note_q.size() > 0 && n < 3000) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n >= 3000) begin
            mismatches = mismatches + 1;
            finish_test;
         end
      end
   endtask
   // the response stands one cycle; look at it mid-cycle
   always @(negedge clk) if (rv === 1'b1) begin
      if (note_q.size() == 0) check({3'h0, rv}, 4'h0);
      else begin
         nt = note_q.pop_front();
         if (nt[4]) check(rd, nt[3:0]);
      end
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         finish_test;
      end
   end
   initial begin
      seed = 32'h1793;
      mismatches = 0;
      cmp_count = 0;
      cycles = 0;
      rst = 1'b1;
      vld = 1'b0;
      cmd = 2'h0;
      adr = 16'h0000;
      wd = 4'h0;
      cbr = 1'b0;
      for (i = 0; i < 65536; i = i + 1) ref_mem[i] = 4'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      i = 0;
      while (idone !== 1'b1 && i < 9000) begin
         @(posedge clk);
         i = i + 1;
      end
      check({3'h0, idone}, 4'h1);
      do_req(`MDC_CMD_WRITE, 16'h1234, 4'ha);
      do_req(`MDC_CMD_WRITE, 16'h1235, 4'h3);
      do_req(`MDC_CMD_READ, 16'h1234, 4'h0);
      do_req(`MDC_CMD_RMW, 16'h1234, 4'h5);
      do_req(`MDC_CMD_READ, 16'h56ff, 4'h0);
      do_req(`MDC_CMD_READ, 16'h1234, 4'h0);
      cbr <= 1'b1;
      repeat (1700) @(posedge clk);
      do_req(`MDC_CMD_READ, 16'h1235, 4'h0);
      cbr <= 1'b0;
      repeat (900) @(posedge clk);
      do_req(`MDC_CMD_READ, 16'h1234, 4'h0);
      for (i = 0; i < 60; i = i + 1) begin
         r = $random(seed);
         cbr <= r[20];
         do_req((r[17:16] == 2'h3) ? 2'h0 : r[17:16],
            {6'h00, r[1:0], r[15:8]}, r[27:24]);
      end
      finish_test;
   end
endmodule // test_multiplexed_dram_cycle_rules
